// ===== hw/mslc_pkg.sv
// constants, register map and carrier types of the modbus link control block
// assumes a 25 MHz system clock and a classic wishbone master
// Function
// - station address 0..199 held; only frames with matching or broadcast address accepted
// - with station address zero, frames to address 255 are taken as ours
// - line rate selectable among eight values, 1200 to 115200 bit/s
// - remote configuration gate allows link config writes when on, refuses when off
// - registers 04h and 05h stay writable over the link regardless of gate
// - gap since last frame beyond timeout forces relays and analogue to alert
// - frame gap timeout 0..99 whole seconds; zero disables supervision
// - turnaround may add 10, 20, 50, 100 or 200 character times
// - standard turnaround: reply allowed at once, no extra delay
// - measurement errors reported as codes 16,68,70,72,73,74,75,96,160
// - measurement status reads zero when valid, else the error code
// - broadcast frames acted upon but never answered
// - one start, eight data, no parity; send two stops, accept one or two
package mslc_pkg;
    localparam int CLK_HZ     = 25_000_000;
    localparam int SEC_CYCLES = CLK_HZ;
    localparam int CHAR_BITS  = 11;
    // 3.5 character silence closes a frame, rounded up to whole bits
    localparam int GAP_BITS   = 39;

    localparam int BAUD0 = 1200;
    localparam int BAUD1 = 2400;
    localparam int BAUD2 = 4800;
    localparam int BAUD3 = 9600;
    localparam int BAUD4 = 19200;
    localparam int BAUD5 = 38400;
    localparam int BAUD6 = 57600;
    localparam int BAUD7 = 115200;

    localparam logic [7:0] TURN_C1 = 8'h0A;
    localparam logic [7:0] TURN_C2 = 8'h14;
    localparam logic [7:0] TURN_C3 = 8'h32;
    localparam logic [7:0] TURN_C4 = 8'h64;
    localparam logic [7:0] TURN_C5 = 8'hC8;

    localparam logic [7:0] STATION_MAX = 8'hC7;
    localparam logic [7:0] ADDR_ALT    = 8'hFF;
    localparam logic [7:0] ADDR_BCAST  = 8'h00;
    localparam logic [7:0] LREG_DP     = 8'h04;
    localparam logic [7:0] LREG_IO     = 8'h05;
    localparam logic [6:0] TMO_MAX     = 7'h63;

    localparam logic [7:0] ERR_CAL   = 8'h10;
    localparam logic [7:0] ERR_SHORT = 8'h44;
    localparam logic [7:0] ERR_OPEN  = 8'h46;
    localparam logic [7:0] ERR_OVV   = 8'h48;
    localparam logic [7:0] ERR_OVC   = 8'h49;
    localparam logic [7:0] ERR_CONV  = 8'h4A;
    localparam logic [7:0] ERR_NOREF = 8'h4B;
    localparam logic [7:0] ERR_UNDER = 8'h60;
    localparam logic [7:0] ERR_OVER  = 8'hA0;

    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_GAPTMO = 8'h04;
    localparam logic [7:0] OFS_RXDATA = 8'h08;
    localparam logic [7:0] OFS_TXDATA = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_MASK   = 8'h14;
    localparam logic [7:0] OFS_RELAY  = 8'h18;
    localparam logic [7:0] OFS_ANALOG = 8'h1C;
    localparam logic [7:0] OFS_ALCFG  = 8'h20;
    localparam logic [7:0] OFS_ALVAL  = 8'h24;
    localparam logic [7:0] OFS_MSTAT  = 8'h28;
    localparam logic [7:0] OFS_WRCHK  = 8'h2C;
    localparam logic [7:0] OFS_LINK   = 8'h30;

    // status / mask bit positions
    localparam int EV_RX    = 0;
    localparam int EV_FRAME = 1;
    localparam int EV_ALERT = 2;
    localparam int EV_TXD   = 3;
    localparam int EV_RXERR = 4;
    localparam int EV_N     = 5;

    localparam logic [7:0] RST_STATION = 8'h01;
    localparam logic [2:0] RST_BAUD    = 3'h3;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } mslc_rx_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } mslc_wb_req_t;

    typedef struct packed {
        logic [31:0] dat;
        logic        ack;
    } mslc_wb_rsp_t;
endpackage

// ===== hw/mslc_link_ctrl.sv
// modbus rtu slave link control: uart, address filter, turnaround, gap alert
// assumes classic wishbone master on clk; rxd/txd already synchronous
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module mslc_link_ctrl #(
    parameter int SEC_CYCLES = mslc_pkg::SEC_CYCLES
) (
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire mslc_pkg::mslc_wb_req_t wb_req,
    output      mslc_pkg::mslc_wb_rsp_t wb_rsp,
    input  wire logic                  rxd,
    output      logic                  txd,
    output      logic                  tx_en,
    input  wire logic [8:0]            meas_fault,
    output      logic [1:0]            relay_o,
    output      logic [15:0]           analog_o,
    output      logic                  alert_o,
    output      logic                  irq
);
    typedef struct packed {
        logic                   ack;
        logic [31:0]            dat;
        logic [7:0]             station;
        logic [2:0]             baud;
        logic                   gate;
        logic [2:0]             turn;
        logic [6:0]             tmo;
        logic [7:0]             rxdata;
        logic                   rxvalid;
        logic [mslc_pkg::EV_N-1:0] sts;
        logic [mslc_pkg::EV_N-1:0] mask;
        logic [1:0]             relay;
        logic [15:0]            analog;
        logic [1:0]             al_relay;
        logic                   keep_r;
        logic                   keep_a;
        logic [15:0]            al_analog;
        logic [7:0]             chk;
        mslc_pkg::mslc_rx_t     rx_st;
        logic [15:0]            rx_cnt;
        logic [2:0]             rx_bit;
        logic [7:0]             rx_sh;
        logic [5:0]             idle_bits;
        logic                   in_frame;
        logic                   addressed;
        logic                   bcast;
        logic                   tx_busy;
        logic [15:0]            tx_cnt;
        logic [3:0]             tx_bit;
        logic [10:0]            tx_sh;
        logic                   tx_line;
        logic                   waiting;
        logic [3:0]             turn_bits;
        logic [7:0]             turn_cnt;
        logic                   permit;
        logic [31:0]            sec_cnt;
        logic [6:0]             gap_sec;
        logic                   alert;
        logic [1:0]             relay_q;
        logic [15:0]            analog_q;
    } st_t;

    st_t r;
    st_t s;

    function automatic logic [15:0] bit_div(input logic [2:0] sel);
        case (sel)
            3'h0:    bit_div = 16'(mslc_pkg::CLK_HZ / mslc_pkg::BAUD0);
            3'h1:    bit_div = 16'(mslc_pkg::CLK_HZ / mslc_pkg::BAUD1);
            3'h2:    bit_div = 16'(mslc_pkg::CLK_HZ / mslc_pkg::BAUD2);
            3'h3:    bit_div = 16'(mslc_pkg::CLK_HZ / mslc_pkg::BAUD3);
            3'h4:    bit_div = 16'(mslc_pkg::CLK_HZ / mslc_pkg::BAUD4);
            3'h5:    bit_div = 16'(mslc_pkg::CLK_HZ / mslc_pkg::BAUD5);
            3'h6:    bit_div = 16'(mslc_pkg::CLK_HZ / mslc_pkg::BAUD6);
            default: bit_div = 16'(mslc_pkg::CLK_HZ / mslc_pkg::BAUD7);
        endcase
    endfunction

    function automatic logic [7:0] turn_chars(input logic [2:0] sel);
        case (sel)
            3'h1:    turn_chars = mslc_pkg::TURN_C1;
            3'h2:    turn_chars = mslc_pkg::TURN_C2;
            3'h3:    turn_chars = mslc_pkg::TURN_C3;
            3'h4:    turn_chars = mslc_pkg::TURN_C4;
            default: turn_chars = mslc_pkg::TURN_C5;
        endcase
    endfunction

    // lowest flag wins when several faults stand at once
    function automatic logic [7:0] err_code(input logic [8:0] f);
        if (f[0])      err_code = mslc_pkg::ERR_CAL;
        else if (f[1]) err_code = mslc_pkg::ERR_SHORT;
        else if (f[2]) err_code = mslc_pkg::ERR_OPEN;
        else if (f[3]) err_code = mslc_pkg::ERR_OVV;
        else if (f[4]) err_code = mslc_pkg::ERR_OVC;
        else if (f[5]) err_code = mslc_pkg::ERR_CONV;
        else if (f[6]) err_code = mslc_pkg::ERR_NOREF;
        else if (f[7]) err_code = mslc_pkg::ERR_UNDER;
        else if (f[8]) err_code = mslc_pkg::ERR_OVER;
        else           err_code = 8'h00;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0]  be);
        for (int i = 0; i < 4; i++) begin
            o[i*8 +: 8] = be[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        end
        merge = o;
    endfunction

    logic [15:0] div;
    logic        req;
    logic        wr;
    logic        idle_tick;
    logic [31:0] wd;
    logic [mslc_pkg::EV_N-1:0] ev;
    logic [mslc_pkg::EV_N-1:0] clr;
    logic        chk_ok;

    always_comb begin
        s         = r;
        div       = bit_div(r.baud);
        req       = wb_req.cyc & wb_req.stb;
        wr        = req & wb_req.we & r.ack;
        wd        = merge(32'h0000_0000, wb_req.dat, wb_req.sel);
        ev        = '0;
        clr       = '0;
        idle_tick = 1'b0;
        chk_ok    = r.gate | (r.chk == mslc_pkg::LREG_DP)
                    | (r.chk == mslc_pkg::LREG_IO);

        // bus: ack one cycle after the strobe, dropped the cycle after
        s.ack = req & ~r.ack;
        if (req & ~r.ack) begin
            case (wb_req.adr)
                mslc_pkg::OFS_CTRL:   s.dat = {17'h0, r.turn, r.gate,
                                               r.baud, r.station};
                mslc_pkg::OFS_GAPTMO: s.dat = {25'h0, r.tmo};
                mslc_pkg::OFS_RXDATA: s.dat = {23'h0, r.rxvalid, r.rxdata};
                mslc_pkg::OFS_TXDATA: s.dat = {30'h0, r.permit, r.tx_busy};
                mslc_pkg::OFS_STATUS: s.dat = {27'h0, r.sts};
                mslc_pkg::OFS_MASK:   s.dat = {27'h0, r.mask};
                mslc_pkg::OFS_RELAY:  s.dat = {30'h0, r.relay};
                mslc_pkg::OFS_ANALOG: s.dat = {16'h0, r.analog};
                mslc_pkg::OFS_ALCFG:  s.dat = {28'h0, r.keep_a, r.keep_r,
                                               r.al_relay};
                mslc_pkg::OFS_ALVAL:  s.dat = {16'h0, r.al_analog};
                mslc_pkg::OFS_MSTAT:  s.dat = {24'h0, err_code(meas_fault)};
                mslc_pkg::OFS_WRCHK:  s.dat = {23'h0, chk_ok, r.chk};
                mslc_pkg::OFS_LINK:   s.dat = {28'h0, r.bcast, r.addressed,
                                               r.in_frame, r.alert};
                default:              s.dat = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            case (wb_req.adr)
                mslc_pkg::OFS_CTRL: begin
                    if (wb_req.sel[0] && wd[7:0] <= mslc_pkg::STATION_MAX) begin
                        s.station = wd[7:0];
                    end
                    if (wb_req.sel[1]) begin
                        s.baud = wd[10:8];
                        s.gate = wd[11];
                        s.turn = wd[14:12];
                    end
                end
                mslc_pkg::OFS_GAPTMO: begin
                    if (wb_req.sel[0] && wd[6:0] <= mslc_pkg::TMO_MAX) begin
                        s.tmo = wd[6:0];
                    end
                end
                mslc_pkg::OFS_RXDATA: s.rxvalid = 1'b0;
                mslc_pkg::OFS_STATUS: clr = wd[mslc_pkg::EV_N-1:0];
                mslc_pkg::OFS_MASK:   s.mask = wd[mslc_pkg::EV_N-1:0];
                mslc_pkg::OFS_RELAY:  s.relay = wd[1:0];
                mslc_pkg::OFS_ANALOG: s.analog = wd[15:0];
                mslc_pkg::OFS_ALCFG: begin
                    s.al_relay = wd[1:0];
                    s.keep_r   = wd[2];
                    s.keep_a   = wd[3];
                end
                mslc_pkg::OFS_ALVAL:  s.al_analog = wd[15:0];
                mslc_pkg::OFS_WRCHK:  s.chk = wd[7:0];
                mslc_pkg::OFS_TXDATA: begin
                    // only inside an open reply window; never after broadcast
                    if (wb_req.sel[0] && r.permit && !r.tx_busy) begin
                        s.tx_sh   = {2'b11, wd[7:0], 1'b0};
                        s.tx_busy = 1'b1;
                        s.tx_cnt  = 16'h0000;
                        s.tx_bit  = 4'h0;
                    end
                end
                default: ;
            endcase
        end

        // receiver, sampled mid-bit; one stop bit is enough
        s.rx_cnt = 16'(r.rx_cnt + 16'h0001);
        case (r.rx_st)
            mslc_pkg::RX_IDLE: begin
                if (r.rx_cnt == 16'(div - 16'h0001)) begin
                    s.rx_cnt  = 16'h0000;
                    idle_tick = 1'b1;
                end
                if (!rxd) begin
                    s.rx_st  = mslc_pkg::RX_START;
                    s.rx_cnt = 16'h0000;
                end
            end
            mslc_pkg::RX_START: begin
                if (r.rx_cnt == {1'b0, div[15:1]}) begin
                    s.rx_st  = rxd ? mslc_pkg::RX_IDLE : mslc_pkg::RX_DATA;
                    s.rx_cnt = 16'h0000;
                    s.rx_bit = 3'h0;
                end
            end
            mslc_pkg::RX_DATA: begin
                if (r.rx_cnt == 16'(div - 16'h0001)) begin
                    s.rx_cnt = 16'h0000;
                    s.rx_sh  = {rxd, r.rx_sh[7:1]};
                    s.rx_bit = 3'(r.rx_bit + 3'h1);
                    if (r.rx_bit == 3'h7) begin
                        s.rx_st = mslc_pkg::RX_STOP;
                    end
                end
            end
            mslc_pkg::RX_STOP: begin
                if (r.rx_cnt == 16'(div - 16'h0001)) begin
                    s.rx_cnt    = 16'h0000;
                    s.rx_st     = mslc_pkg::RX_IDLE;
                    s.idle_bits = 6'h00;
                    s.permit    = 1'b0;
                    s.waiting   = 1'b0;
                    if (!rxd) begin
                        ev[mslc_pkg::EV_RXERR] = 1'b1;
                        s.addressed = 1'b0;
                        s.in_frame  = 1'b1;
                    end else if (!r.in_frame) begin
                        s.in_frame  = 1'b1;
                        s.bcast     = r.rx_sh == mslc_pkg::ADDR_BCAST;
                        s.addressed = (r.rx_sh == r.station)
                            | (r.station == 8'h00
                               && r.rx_sh == mslc_pkg::ADDR_ALT)
                            | (r.rx_sh == mslc_pkg::ADDR_BCAST);
                        s.rxdata  = s.addressed ? r.rx_sh : r.rxdata;
                        s.rxvalid = s.addressed;
                        ev[mslc_pkg::EV_RX] = s.addressed;
                    end else if (r.addressed) begin
                        s.rxdata  = r.rx_sh;
                        s.rxvalid = 1'b1;
                        ev[mslc_pkg::EV_RX] = 1'b1;
                    end
                end
            end
            default: s.rx_st = mslc_pkg::RX_IDLE;
        endcase

        // silence ends the frame; accepted frames feed supervision
        if (idle_tick && r.idle_bits != 6'(mslc_pkg::GAP_BITS)) begin
            s.idle_bits = 6'(r.idle_bits + 6'h01);
            if (r.idle_bits == 6'(mslc_pkg::GAP_BITS - 1) && r.in_frame) begin
                s.in_frame = 1'b0;
                if (r.addressed) begin
                    ev[mslc_pkg::EV_FRAME] = 1'b1;
                    if (!r.bcast) begin
                        s.permit    = r.turn == 3'h0;
                        s.waiting   = r.turn != 3'h0;
                        s.turn_bits = 4'h0;
                        s.turn_cnt  = 8'h00;
                    end
                end
            end
        end

        // extra turnaround counted in character times of the line rate
        if (r.waiting && idle_tick) begin
            s.turn_bits = 4'(r.turn_bits + 4'h1);
            if (r.turn_bits == 4'(mslc_pkg::CHAR_BITS - 1)) begin
                s.turn_bits = 4'h0;
                s.turn_cnt  = 8'(r.turn_cnt + 8'h01);
                if (r.turn_cnt == 8'(turn_chars(r.turn) - 8'h01)) begin
                    s.waiting = 1'b0;
                    s.permit  = 1'b1;
                end
            end
        end

        // transmitter: start, eight data, two stop bits
        if (r.tx_busy) begin
            s.tx_cnt = 16'(r.tx_cnt + 16'h0001);
            if (r.tx_cnt == 16'h0000) begin
                s.tx_line = r.tx_sh[0];
            end
            if (r.tx_cnt == 16'(div - 16'h0001)) begin
                s.tx_cnt = 16'h0000;
                s.tx_sh  = {1'b1, r.tx_sh[10:1]};
                s.tx_bit = 4'(r.tx_bit + 4'h1);
                if (r.tx_bit == 4'(mslc_pkg::CHAR_BITS - 1)) begin
                    s.tx_busy = 1'b0;
                    ev[mslc_pkg::EV_TXD] = 1'b1;
                end
            end
        end else begin
            s.tx_line = 1'b1;
        end

        // frame gap supervision in whole seconds
        s.sec_cnt = 32'(r.sec_cnt + 32'h0000_0001);
        if (r.sec_cnt == 32'(SEC_CYCLES - 1)) begin
            s.sec_cnt = 32'h0000_0000;
            if (r.tmo != 7'h00 && !r.alert) begin
                if (r.gap_sec == r.tmo) begin
                    s.alert = 1'b1;
                    ev[mslc_pkg::EV_ALERT] = 1'b1;
                end else begin
                    s.gap_sec = 7'(r.gap_sec + 7'h01);
                end
            end
        end
        if (r.tmo == 7'h00) begin
            s.alert   = 1'b0;
            s.gap_sec = 7'h00;
        end
        // frame end outranks a second tick in the same cycle
        if (ev[mslc_pkg::EV_FRAME]) begin
            s.sec_cnt = 32'h0000_0000;
            s.gap_sec = 7'h00;
            s.alert   = 1'b0;
            ev[mslc_pkg::EV_ALERT] = 1'b0;
        end

        // set wins over a simultaneous write-one clear
        s.sts = (r.sts & ~clr) | ev;

        // link-driven outputs, forced while alert unless told to keep
        s.relay_q  = (r.alert && !r.keep_r) ? r.al_relay : r.relay;
        s.analog_q = (r.alert && !r.keep_a) ? r.al_analog : r.analog;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r         <= '0;
            r.station <= mslc_pkg::RST_STATION;
            r.baud    <= mslc_pkg::RST_BAUD;
            r.rx_st   <= mslc_pkg::RX_IDLE;
            r.tx_sh   <= '1;
            r.tx_line <= 1'b1;
        end else begin
            r <= s;
        end
    end

    assign wb_rsp.ack = r.ack;
    assign wb_rsp.dat = r.dat;
    assign txd        = r.tx_line;
    assign tx_en      = r.tx_busy;
    assign relay_o    = r.relay_q;
    assign analog_o   = r.analog_q;
    assign alert_o    = r.alert;
    assign irq        = |(r.sts & r.mask);
endmodule // mslc_link_ctrl

// ===== tb/mslc_link_ctrl_properties.sv
// port checker for the modbus link control block
// assumes it is bound onto mslc_link_ctrl, one clock domain
`timescale 1ns/100ps
module mslc_link_props (
    input wire logic                   clk,
    input wire logic                   resetn,
    input wire mslc_pkg::mslc_wb_req_t wb_req,
    input wire mslc_pkg::mslc_wb_rsp_t wb_rsp,
    input wire logic                   txd,
    input wire logic                   tx_en,
    input wire logic [1:0]             relay_o,
    input wire logic [15:0]            analog_o,
    input wire logic                   alert_o
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic req;
    logic wr;
    assign req = wb_req.cyc && wb_req.stb;
    assign wr  = wb_rsp.ack && wb_req.we;

    a_ack_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property ((req && !wb_rsp.ack) |=> wb_rsp.ack)
        else $error("request not answered next cycle");
    a_ack_cause: assert property (wb_rsp.ack |-> $past(req))
        else $error("ack without request");
    a_txd_idle: assert property (!tx_en |-> txd)
        else $error("txd low while driver off");
    a_start_bit: assert property ($rose(tx_en) |=> !txd)
        else $error("no start bit after enable");
    a_stop_high: assert property ($fell(tx_en) |-> $past(txd))
        else $error("last stop bit not high");
    a_tx_cause: assert property ($rose(tx_en) |-> $past(wr) || $past(wr, 2))
        else $error("transmit without a register write");
    // outputs move only after a register write or an alert edge
    a_relay_source: assert property ($changed(relay_o) |->
        $past(wr) || $past(wr, 2) || $past(wr, 3) ||
        $past(alert_o) != $past(alert_o, 2))
        else $error("relay output changed without cause");
    a_analog_source: assert property ($changed(analog_o) |->
        $past(wr) || $past(wr, 2) || $past(wr, 3) ||
        $past(alert_o) != $past(alert_o, 2))
        else $error("analogue output changed without cause");
endmodule // mslc_link_props

bind mslc_link_ctrl mslc_link_props u_mslc_link_props (
    .clk(clk), .resetn(resetn), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .txd(txd), .tx_en(tx_en), .relay_o(relay_o), .analog_o(analog_o),
    .alert_o(alert_o)
);

// ===== tb/mslc_master_model.sv
// modbus master model: sends bytes on rxd, decodes replies from txd
// assumes the block clock and a fixed bit period in clocks
`timescale 1ns/100ps
module mslc_master_model #(
    parameter int DIV = 217
) (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [7:0] byte_i,
    input  wire logic       txd,
    output      logic       rxd,
    output      logic       busy,
    output      logic       got,
    output      logic [7:0] got_byte
);
    initial begin
        rxd = 1'b1;
        busy = 1'b0;
        got = 1'b0;
        got_byte = 8'h00;
    end
    // bus bias holds the line high between characters
    always @(posedge clk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            for (int i = 0; i < 11; i++) begin
                rxd <= (i == 0) ? 1'b0 : (i > 8) ? 1'b1 : byte_i[i - 1];
                repeat (DIV) @(posedge clk);
            end
            busy <= 1'b0;
        end
    end
    // mid-bit sampling; a low stop level drops the byte
    always begin
        logic [8:0] sh;
        @(negedge txd);
        repeat (DIV / 2) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            repeat (DIV) @(posedge clk);
            sh[i] = txd;
        end
        got_byte <= sh[7:0];
        got <= sh[8];
        @(posedge clk);
        got <= 1'b0;
    end
endmodule // mslc_master_model

// ===== tb/tb_mslc_link_ctrl.sv
// self-checking bench for the modbus link control block
// assumes the master model and the bound port checker
`timescale 1ns/100ps
module tb_mslc_link_ctrl;
    localparam int SEC = 60;
    localparam int DIV = 217; // 115200 bit/s at 25 MHz
    logic                   clk = 1'b0;
    logic                   resetn = 1'b0;
    mslc_pkg::mslc_wb_req_t req = '0;
    mslc_pkg::mslc_wb_rsp_t rsp;
    logic                   rxd, txd, tx_en, alert_o, irq, go = 1'b0;
    logic                   got, busy;
    logic [8:0]             meas_fault = '0;
    logic [1:0]             relay_o;
    logic [15:0]            analog_o;
    logic [7:0]             tx_b = '0, got_b, st;
    logic [31:0]            exp_q[$];
    string                  nam_q[$];
    int                     mismatches = 0, checked = 0;
    logic [7:0] codes [9] = '{8'h10, 8'h44, 8'h46, 8'h48, 8'h49,
                              8'h4A, 8'h4B, 8'h60, 8'hA0};
    always #20 clk = ~clk;
    mslc_link_ctrl #(.SEC_CYCLES(SEC)) u_mslc_link_ctrl (.clk(clk),
        .resetn(resetn), .wb_req(req), .wb_rsp(rsp), .rxd(rxd), .txd(txd),
        .tx_en(tx_en), .meas_fault(meas_fault), .relay_o(relay_o),
        .analog_o(analog_o), .alert_o(alert_o), .irq(irq));
    mslc_master_model #(.DIV(DIV)) u_mslc_master_model (.clk(clk),
        .go(go), .byte_i(tx_b), .txd(txd), .rxd(rxd), .busy(busy),
        .got(got), .got_byte(got_b));
    task automatic check(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wb(input logic [7:0] a, input logic w, logic [31:0] d);
        req <= '{1'b1, 1'b1, w, a, 4'hF, d};
        do begin
            @(posedge clk);
        end while (rsp.ack !== 1'b1);
        req <= '0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, logic [31:0] e, string n);
        exp_q.push_back(e);
        nam_q.push_back(n);
        wb(a, 1'b0, 32'h0);
    endtask
    // one byte frame, then wait out the end-of-frame silence
    task automatic frame(input logic [7:0] b);
        go <= 1'b1;
        tx_b <= b;
        @(posedge busy);
        go <= 1'b0;
        @(negedge busy);
        repeat (41 * DIV) @(posedge clk);
    endtask
    always @(posedge clk) begin
        if ((rsp.ack === 1'b1 && req.we === 1'b0 || got === 1'b1) &&
            exp_q.size() > 0)
            check(nam_q.pop_front(), got ? 32'(got_b) : rsp.dat,
                  exp_q.pop_front());
    end
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        stop_test();
    end
    initial begin
        logic [7:0]  b;
        logic [15:0] av, lv;
        void'($urandom(32'h592B));
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(8'h00, 32'h301, "ctrl_reset");
        rd(8'hFC, 32'h0, "unmapped");
        rd(8'h28, 32'h0, "mstat_valid");
        for (int i = 0; i < 9; i++) begin
            meas_fault <= 9'h001 << i;
            rd(8'h28, 32'(codes[i]), "mstat_code");
        end
        meas_fault <= 9'h000;
        for (int i = 0; i < 8; i++) begin
            wb(8'h00, 1'b1, 32'(i) << 8 | 32'h1);
            rd(8'h00, 32'(i) << 8 | 32'h1, "baud_code");
        end
        st = 8'(1 + $urandom % 198);
        wb(8'h00, 1'b1, 32'h700 | 32'(st));
        wb(8'h00, 1'b1, 32'h7C8);
        rd(8'h00, 32'h700 | 32'(st), "station");
        wb(8'h04, 1'b1, 32'h63);
        wb(8'h04, 1'b1, 32'h64);
        rd(8'h04, 32'h63, "gap_tmo");
        wb(8'h04, 1'b1, 32'h0);
        for (int g = 0; g < 2; g++) begin
            wb(8'h00, 1'b1, 32'(g) << 11 | 32'h700 | 32'(st));
            for (int r = 4; r < 7; r++) begin
                wb(8'h2C, 1'b1, 32'(r));
                rd(8'h2C, 32'(r) | 32'(g == 1 || r < 6) << 8, "gate");
            end
        end
        frame(st);
        rd(8'h08, 32'h100 | 32'(st), "rx_own");
        rd(8'h0C, 32'h2, "window_std");
        rd(8'h10, 32'h3, "status_frame");
        wb(8'h10, 1'b1, 32'h1F);
        b = 8'($urandom);
        exp_q.push_back(32'(b));
        nam_q.push_back("tx_byte");
        wb(8'h0C, 1'b1, 32'(b));
        @(negedge tx_en);
        wb(8'h08, 1'b1, 32'h0);
        frame(st + 8'h01);
        rd(8'h08, 32'(st), "rx_other");
        rd(8'h0C, 32'h0, "window_other");
        frame(8'h00);
        rd(8'h08, 32'h100, "rx_bcast");
        rd(8'h0C, 32'h0, "window_bcast");
        wb(8'h00, 1'b1, 32'h1700);
        frame(8'hFF);
        rd(8'h0C, 32'h0, "turn_wait");
        repeat (110 * DIV) @(posedge clk);
        rd(8'h0C, 32'h2, "turn_open");
        av = 16'($urandom);
        lv = 16'($urandom);
        wb(8'h20, 1'b1, 32'h2);
        wb(8'h24, 1'b1, 32'(av));
        wb(8'h18, 1'b1, 32'h1);
        wb(8'h1C, 1'b1, 32'(lv));
        wb(8'h14, 1'b1, 32'h4);
        wb(8'h04, 1'b1, 32'h63);
        frame(8'hFF);
        wb(8'h10, 1'b1, 32'h1F);
        check("alert_cleared", 32'(alert_o), 32'h0);
        check("relay_link", 32'(relay_o), 32'h1);
        repeat (5000) @(posedge clk);
        check("alert_early", 32'(alert_o), 32'h0);
        repeat (1000) @(posedge clk);
        check("alert_set", 32'(alert_o), 32'h1);
        check("relay_alert", 32'(relay_o), 32'h2);
        check("analog_alert", 32'(analog_o), 32'(av));
        check("irq_on", 32'(irq), 32'h1);
        rd(8'h10, 32'h4, "status_alert");
        wb(8'h14, 1'b1, 32'h0);
        check("irq_masked", 32'(irq), 32'h0);
        wb(8'h04, 1'b1, 32'h0);
        repeat (3) @(posedge clk);
        check("alert_off", 32'(alert_o), 32'h0);
        check("analog_link", 32'(analog_o), 32'(lv));
        stop_test();
    end
endmodule // tb_mslc_link_ctrl
